// ===== pkg/outport_pkg.sv
/*
 Constants for the general output port stage: field positions, reset
 values, frequency-select codes and divider taps.
 Assumes the including code refers to every item as outport_pkg::name.
*/
// Behaviour
// - Float bit one releases the pin(s)
// - Float bit zero drives pin from data
// - Four single floats, two group floats
// - Reset: data ones, floats zero, pins high
// - Pins 2/3 select timer/osc clock outputs
// - Data zero forces special pin low
// - Float one overrides special clock output
// - Pin 2 clock comes from timer
// - Two-bit code selects pin 3 clock
// - Clock gating not glitch-free on enable
package outport_pkg;
    localparam int          PORT_W        = 12;
    localparam int          FLOAT_W       = 6;
    localparam int          SPEC_W        = 4;
    // Float control field positions
    localparam int          FLT_PIN0      = 0;
    localparam int          FLT_PIN1      = 1;
    localparam int          FLT_PIN2      = 2;
    localparam int          FLT_PIN3      = 3;
    localparam int          FLT_GROUP1    = 4;
    localparam int          FLT_GROUP2    = 5;
    // Port pin positions
    localparam int          PIN2          = 2;
    localparam int          PIN3          = 3;
    localparam int          GROUP1_LSB    = 4;
    localparam int          GROUP2_LSB    = 8;
    localparam int          GROUP_W       = 4;
    // Special output control field positions
    localparam int          SPC_TIMER_EN  = 0;
    localparam int          SPC_OSC_EN    = 1;
    localparam int          SPC_FREQ_LO   = 2;
    localparam int          SPC_FREQ_HI   = 3;
    // Reset values
    localparam logic [11:0] DATA_RST      = 12'hFFF;
    localparam logic [5:0]  FLOAT_RST     = 6'h00;
    localparam logic [3:0]  SPEC_RST      = 4'h0;
    // Pin 3 frequency codes
    localparam logic [1:0]  FREQ_HIGH     = 2'h3;
    localparam logic [1:0]  FREQ_LOW      = 2'h2;
    localparam logic [1:0]  FREQ_DIV8     = 2'h1;
    localparam logic [1:0]  FREQ_DIV64    = 2'h0;
    // Divider: counter bit that toggles at each ratio
    localparam int          DIV_CNT_W     = 6;
    localparam int          DIV8_TAP      = 2;
    localparam int          DIV64_TAP     = 5;
    localparam logic [5:0]  DIV_CNT_RST   = 6'h00;
    localparam logic [5:0]  DIV_CNT_ONE   = 6'h01;
endpackage

// ===== pkg/osc_div_if.sv
/*
 Carrier between the port stage and its low-speed clock divider.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface osc_div_if;
    logic low_osc_clock;
    logic div8_clock;
    logic div64_clock;
    modport port_end (output low_osc_clock, input div8_clock, div64_clock);
    modport div_end  (input low_osc_clock, output div8_clock, div64_clock);
endinterface
`default_nettype wire

// ===== logic/osc_clock_divider.sv
/*
 Divides the sampled low-speed oscillator clock by 8 and by 64.
 Assumes low_osc_clock is synchronous to clk_sys and slower than half its rate.
*/
`timescale 1ns/10ps
`default_nettype none
module osc_clock_divider (
    input  wire logic clk_sys,
    input  wire logic nrst,
    osc_div_if.div_end div
);
    logic                                    prev_q;
    logic [outport_pkg::DIV_CNT_W-1:0]       cnt_q;
    logic [outport_pkg::DIV_CNT_W-1:0]       cnt_d;
    logic                                    rise;

    // Rising edge of the slow clock advances the counter
    assign rise  = div.low_osc_clock & ~prev_q;
    assign cnt_d = rise ? cnt_q + outport_pkg::DIV_CNT_ONE : cnt_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
            cnt_q  <= outport_pkg::DIV_CNT_RST;
        end else begin
            prev_q <= div.low_osc_clock;
            cnt_q  <= cnt_d;
        end
    end

    // Counter bits are the divided clocks
    assign div.div8_clock  = cnt_q[outport_pkg::DIV8_TAP];
    assign div.div64_clock = cnt_q[outport_pkg::DIV64_TAP];
endmodule
`default_nettype wire

// ===== logic/output_port_hiz_special_clock.sv
/*
 Output stage of the 12-bit general output port with float control and
 the timer and oscillator clock outputs on pins 2 and 3.
 Pin map: bits 0-3 are port 0, bits 4-7 port 1, bits 8-11 port 2.
 Float map: bits 0-3 float single pins 0-3, bit 4 port 1, bit 5 port 2.
 Port 1 and port 2 float only as whole groups of four.
 Special map: bit 0 timer enable, bit 1 oscillator enable, bits 3:2
 the pin 3 frequency code.
 Every pin leaves through a flip-flop, so port_out and port_oe lag by one cycle.
 A floated pin keeps its level in the pin register; only port_oe drops.
 The clock gating is a plain AND, so enable edges may clip a pulse.
 Assumes every input is synchronous to clk_sys, write strobes are one
 cycle wide, and the pad logic resolves the wire from port_oe.
 Assumes the timer and oscillator clocks run and are settled whenever
 software turns on their outputs.
 Assumes low_osc_clock runs below half the rate of clk_sys, so the
 divider sees every one of its edges.
*/
`timescale 1ns/10ps
`default_nettype none
module output_port_hiz_special_clock (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        data_wr,
    input  wire logic [11:0] data_wdata,
    input  wire logic        float_wr,
    input  wire logic [5:0]  float_wdata,
    input  wire logic        spec_wr,
    input  wire logic [3:0]  spec_wdata,
    output logic      [11:0] data_rdata,
    output logic      [5:0]  float_rdata,
    output logic      [3:0]  spec_rdata,
    input  wire logic        timer_clock,
    input  wire logic        low_osc_clock,
    input  wire logic        high_osc_clock,
    output logic      [11:0] port_out,
    output logic      [11:0] port_oe
);
    // Stored control registers
    logic [11:0] data_q;
    logic [11:0] data_d;
    logic [5:0]  float_q;
    logic [5:0]  float_d;
    logic [3:0]  spec_q;
    logic [3:0]  spec_d;
    // Pin lane flip-flops and their next values
    logic [11:0] out_q;
    logic [11:0] out_d;
    logic [11:0] oe_q;
    logic [11:0] oe_d;
    // Decoded controls and gated clocks
    logic [11:0] pin_float;
    logic [1:0]  freq_sel;
    logic        osc_sel_clock;
    logic        timer_en;
    logic        osc_en;
    logic [1:0]  pin2_drive;
    logic [1:0]  pin3_drive;
    // Per-group views of the float register
    logic [3:0]  port0_float;
    logic        group1_float;
    logic        group2_float;
    // Divided low-speed clocks
    logic        div8_clock;
    logic        div64_clock;
    // Ordinary pin levels and enables before the special patch
    logic [11:0] plain_out;
    logic [11:0] plain_oe;
    // Special pin lanes
    logic        pin2_level;
    logic        pin2_enable;
    logic        pin3_level;
    logic        pin3_enable;

    // Low-speed divider lives in its own module behind the carrier
    osc_div_if div_bus ();

    osc_clock_divider u_div (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .div     (div_bus.div_end)
    );

    assign div_bus.low_osc_clock = low_osc_clock;

    // Divided clocks come back through the carrier
    assign div8_clock  = div_bus.div8_clock;
    assign div64_clock = div_bus.div64_clock;

    // Returns {output enable, level}; float wins, then data zero, then clock
    // Both special pins share this rule, so one function serves both lanes
    function automatic logic [1:0] pin_drive(input logic data, input logic flt,
                                             input logic spec_en, input logic clk);
        logic lvl;
        lvl = data & (spec_en ? clk : 1'b1);
        pin_drive = {~flt, lvl};
    endfunction

    // Spreads the six float bits over the twelve pins
    // Group bits cover four pins each, single bits one pin
    function automatic logic [11:0] float_pins(input logic [3:0] pin_bits, input logic grp1,
                                               input logic grp2);
        logic [11:0] pins;
        pins = {{outport_pkg::GROUP_W{grp2}}, {outport_pkg::GROUP_W{grp1}}, pin_bits};
        float_pins = pins;
    endfunction

    // Picks the pin 3 source for a frequency code
    // All four codes are decoded; the default only guards unknown levels
    function automatic logic osc_source(input logic [1:0] code, input logic fast,
                                        input logic slow, input logic slow8,
                                        input logic slow64);
        logic pick;
        case (code)
            outport_pkg::FREQ_HIGH:  pick = fast;
            outport_pkg::FREQ_LOW:   pick = slow;
            outport_pkg::FREQ_DIV8:  pick = slow8;
            outport_pkg::FREQ_DIV64: pick = slow64;
            default:                 pick = slow64;
        endcase
        osc_source = pick;
    endfunction

    // Register write paths with hold
    // A strobe loads the whole field; there are no partial writes
    assign data_d  = data_wr  ? data_wdata  : data_q;
    assign float_d = float_wr ? float_wdata : float_q;
    assign spec_d  = spec_wr  ? spec_wdata  : spec_q;

    // Data register; reset loads ones so every pin starts high
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_q <= outport_pkg::DATA_RST;
        end else begin
            data_q <= data_d;
        end
    end

    // Float register; reset leaves every pin driven
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            float_q <= outport_pkg::FLOAT_RST;
        end else begin
            float_q <= float_d;
        end
    end

    // Special control register; reset turns both clock outputs off
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            spec_q <= outport_pkg::SPEC_RST;
        end else begin
            spec_q <= spec_d;
        end
    end

    // Readback of the last written values
    // Plain reads with no side effects, so polling is harmless
    assign data_rdata  = data_q;
    assign float_rdata = float_q;
    assign spec_rdata  = spec_q;

    // Expand float controls: four single pins, two groups of four
    assign port0_float  = float_q[outport_pkg::FLT_PIN3:outport_pkg::FLT_PIN0];
    assign group1_float = float_q[outport_pkg::FLT_GROUP1];
    assign group2_float = float_q[outport_pkg::FLT_GROUP2];
    assign pin_float    = float_pins(port0_float, group1_float, group2_float);

    // Pin 3 clock source selection
    // Divided taps come from the divider's flip-flops, one cycle later
    assign freq_sel      = {spec_q[outport_pkg::SPC_FREQ_HI], spec_q[outport_pkg::SPC_FREQ_LO]};
    assign osc_sel_clock = osc_source(freq_sel, high_osc_clock, low_osc_clock,
                                      div8_clock, div64_clock);

    // Plain AND gating of the clocks, so enable edges may clip a pulse
    // A short runt pulse can reach the pin when an enable bit flips in the middle of a clock phase
    assign timer_en   = spec_q[outport_pkg::SPC_TIMER_EN];
    assign osc_en     = spec_q[outport_pkg::SPC_OSC_EN];
    assign pin2_drive = pin_drive(data_q[outport_pkg::PIN2], pin_float[outport_pkg::PIN2],
                                  timer_en, timer_clock);
    assign pin3_drive = pin_drive(data_q[outport_pkg::PIN3], pin_float[outport_pkg::PIN3],
                                  osc_en, osc_sel_clock);

    // Split each lane result into its level and its enable
    // Bit 1 of each result is the enable, bit 0 the level
    assign pin2_level  = pin2_drive[0];
    assign pin2_enable = pin2_drive[1];
    assign pin3_level  = pin3_drive[0];
    assign pin3_enable = pin3_drive[1];

    // Ordinary pins drive data unless floating
    // A floated pin keeps its level, ready for release
    assign plain_out = data_q;
    assign plain_oe  = ~pin_float;

    // Special pins patched in over the ordinary lanes of port 0
    assign out_d = {plain_out[outport_pkg::PORT_W-1:outport_pkg::GROUP1_LSB], pin3_level, pin2_level,
                    plain_out[outport_pkg::PIN2-1:0]};
    assign oe_d  = {plain_oe[outport_pkg::PORT_W-1:outport_pkg::GROUP1_LSB], pin3_enable, pin2_enable,
                    plain_oe[outport_pkg::PIN2-1:0]};

    // Pin levels; reset drives every pin high
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_q <= outport_pkg::DATA_RST;
        end else begin
            out_q <= out_d;
        end
    end

    // Pin drive enables; reset leaves every pin driven
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oe_q <= ~outport_pkg::FLOAT_RST[0] ? 12'hFFF : 12'h000;
        end else begin
            oe_q <= oe_d;
        end
    end

    // Pins leave straight from the flip-flops
    assign port_out = out_q;
    assign port_oe  = oe_q;
endmodule
`default_nettype wire

// ===== verif/output_port_assertions.sv
/* Checker for the port stage: write-back and pin relations.
   Assumes it is bound to the port stage top module. */
`timescale 1ns/10ps
`default_nettype none
module output_port_assertions (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        data_wr,
    input wire logic [11:0] data_wdata,
    input wire logic        float_wr,
    input wire logic [5:0]  float_wdata,
    input wire logic        spec_wr,
    input wire logic [3:0]  spec_wdata,
    input wire logic [11:0] data_rdata,
    input wire logic [5:0]  float_rdata,
    input wire logic [3:0]  spec_rdata,
    input wire logic        timer_clock,
    input wire logic        low_osc_clock,
    input wire logic        high_osc_clock,
    input wire logic [11:0] port_out,
    input wire logic [11:0] port_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Register write-back
    data_wb_a: assert property (data_wr |=> data_rdata == $past(data_wdata))
        else $error("data readback wrong");
    float_wb_a: assert property (float_wr |=> float_rdata == $past(float_wdata))
        else $error("float readback wrong");
    spec_wb_a: assert property (spec_wr |=> spec_rdata == $past(spec_wdata))
        else $error("special readback wrong");
    // Drive enables follow float bits
    pin_float_a: assert property (port_oe[3:0] == ~$past(float_rdata[3:0]))
        else $error("single float wrong");
    group_float_a: assert property (port_oe[11:4] == {{4{~$past(float_rdata[5])}}, {4{~$past(float_rdata[4])}}})
        else $error("group float wrong");
    // Pin levels
    plain_data_a: assert property ({port_out[11:4], port_out[1:0]} == $past({data_rdata[11:4], data_rdata[1:0]}))
        else $error("plain pin level wrong");
    timer_out_a: assert property (port_out[2] == $past(data_rdata[2] & (spec_rdata[0] ? timer_clock : 1'b1)))
        else $error("timer pin wrong");
    osc_high_a: assert property ($past(spec_rdata == 4'hE) |-> port_out[3] == $past(data_rdata[3] & high_osc_clock))
        else $error("fast clock pin wrong");
    low_force_a: assert property (!$past(data_rdata[3]) |-> !port_out[3])
        else $error("pin3 not held low");
    float_c: cover property (float_wr ##2 port_oe != 12'hFFF);
    timer_c: cover property (spec_rdata[0] && float_rdata == 6'h00);
    osc_c: cover property (spec_rdata == 4'hE);
endmodule
bind output_port_hiz_special_clock output_port_assertions chk (.clk_sys(clk_sys), .nrst(nrst),
    .data_wr(data_wr), .data_wdata(data_wdata), .float_wr(float_wr), .float_wdata(float_wdata),
    .spec_wr(spec_wr), .spec_wdata(spec_wdata), .data_rdata(data_rdata), .float_rdata(float_rdata),
    .spec_rdata(spec_rdata), .timer_clock(timer_clock), .low_osc_clock(low_osc_clock),
    .high_osc_clock(high_osc_clock), .port_out(port_out), .port_oe(port_oe));
`default_nettype wire

// ===== verif/ext_device_model.sv
/* External devices on the port pins: resolve pin levels, count pin 3 rises.
   Assumes port_out and port_oe come straight from the port stage. */
`timescale 1ns/10ps
`default_nettype none
module ext_device_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] port_out,
    input  wire logic [11:0] port_oe,
    output logic      [11:0] pin_level,
    output int               pin3_rises
);
    logic [11:0] drv_q   = 12'h000;
    logic        prev3_q = 1'b0;
    int          rises_q = 0;
    // Floating pins show the inverse of the last driven level, no pull
    assign pin_level  = (port_out & port_oe) | (~drv_q & ~port_oe);
    assign pin3_rises = rises_q;
    // Remember driven levels; count rising edges on the clock pin
    always @(posedge clk_sys) begin
        drv_q   <= (port_out & port_oe) | (drv_q & ~port_oe);
        prev3_q <= pin_level[3];
        if (pin_level[3] && !prev3_q) rises_q <= rises_q + 1;
    end
endmodule
`default_nettype wire

// ===== verif/output_port_hiz_special_clock_tb.sv
/* Self-checking bench for the port stage.
   Assumes the checker is bound and the source clocks are synchronous. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module output_port_hiz_special_clock_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, data_wr = 1'b0, float_wr = 1'b0, spec_wr = 1'b0;
    logic timer_clock = 1'b0, low_osc_clock = 1'b0, high_osc_clock = 1'b0;
    logic [11:0] data_wdata = 12'hFFF, data_rdata, port_out, port_oe, pin_level;
    logic [5:0]  float_wdata = 6'h00, float_rdata;
    logic [3:0]  spec_wdata = 4'h0, spec_rdata;
    int          errors = 0, checks_done = 0, ph = 0, pin3_rises;
    always #5 clk_sys = ~clk_sys;
    // Source clocks: fast period 2, low period 4, timer period 6
    always @(negedge clk_sys) begin
        ph <= ph + 1;
        high_osc_clock <= ~high_osc_clock;
        if (ph % 2 == 1) low_osc_clock <= ~low_osc_clock;
        if (ph % 3 == 0) timer_clock <= ~timer_clock;
    end
    output_port_hiz_special_clock DUT (.clk_sys(clk_sys), .nrst(nrst), .data_wr(data_wr),
        .data_wdata(data_wdata), .float_wr(float_wr), .float_wdata(float_wdata), .spec_wr(spec_wr),
        .spec_wdata(spec_wdata), .data_rdata(data_rdata), .float_rdata(float_rdata),
        .spec_rdata(spec_rdata), .timer_clock(timer_clock), .low_osc_clock(low_osc_clock),
        .high_osc_clock(high_osc_clock), .port_out(port_out), .port_oe(port_oe));
    ext_device_model ext (.clk_sys(clk_sys), .port_out(port_out), .port_oe(port_oe),
        .pin_level(pin_level), .pin3_rises(pin3_rises));
    // Write one register, check read-back, let the pins settle
    task automatic wr(input int k, input logic [11:0] v);
        @(negedge clk_sys);
        {data_wr, float_wr, spec_wr} = {k == 0, k == 1, k == 2};
        {data_wdata, float_wdata, spec_wdata} = {v, v[5:0], v[3:0]};
        @(negedge clk_sys);
        {data_wr, float_wr, spec_wr} = 3'h0;
        `CHK(k == 0 ? data_rdata : k == 1 ? {6'h00, float_rdata} : {8'h00, spec_rdata}, v)
        @(negedge clk_sys);
    endtask
    task automatic t_reset();
        `CHK({data_rdata, float_rdata, spec_rdata, port_out, port_oe}, {12'hFFF, 6'h00, 4'h0, 24'hFFFFFF})
        $display("test reset done");
    endtask
    task automatic t_float();
        for (int i = 0; i < 6; i++) begin
            wr(1, 12'h001 << i);
            `CHK(port_oe, ~(i < 4 ? 12'h001 << i : i == 4 ? 12'h0F0 : 12'hF00))
        end
        wr(1, 12'h000);
        wr(0, 12'hA5A);
        `CHK({port_out, port_oe}, 24'hA5AFFF)
        `CHK(pin_level, 12'hA5A)
        wr(0, 12'hFFF);
        $display("test float done");
    endtask
    task automatic t_special();
        logic acc;
        logic [1:0] seen;
        acc = 1'b0;
        seen = 2'h0;
        wr(2, 12'h001);
        repeat (12) @(negedge clk_sys) seen |= {~port_out[2], port_out[2]};
        `CHK(seen, 2'h3)
        wr(0, 12'hFFB);
        repeat (8) @(negedge clk_sys) acc |= port_out[2];
        `CHK(acc, 1'b0)
        wr(0, 12'hFFF);
        wr(1, 12'h004);
        `CHK(port_oe[2], 1'b0)
        wr(1, 12'h000);
        wr(2, 12'h000);
        $display("test special done");
    endtask
    task automatic t_freq();
        int n0, n, ex;
        for (int c = 0; c < 4; c++) begin
            wr(2, 12'h002 | (c << 2));
            n0 = pin3_rises;
            repeat (512) @(negedge clk_sys);
            n = pin3_rises - n0;
            ex = c == 3 ? 256 : c == 2 ? 128 : c == 1 ? 16 : 2;
            `CHK(n >= ex - 1 && n <= ex + 1, 1'b1)
        end
        wr(2, 12'h000);
        $display("test freq done");
    endtask
    task automatic final_report();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        final_report();
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_float();
        t_special();
        t_freq();
        final_report();
    end
endmodule
`default_nettype wire
